// ---- core/scm_ctrl.sv ----
`timescale 1ns/1ps
// Behaviour
// - system clock from fast or sub clock
// - select 000 to 110: fast clock divided
// - select 111: slow mode on sub clock
// - fast clock from crystal or rc
// - sub clock from watch crystal or rc
// - fast oscillator in slow mode follows enable
// - six modes, cpu runs only fast/slow
// - halt, no keep bits: sleep, all stop
// - sleep keeps slow rc only for watchdog
// - halt slow keep only: idle slow only
// - halt both keeps: idle both oscillators
// - halt fast keep only: idle fast only
// - source bits: 0 rc, 1 crystal
// - rc frequency 4, 8, 12, 4 MHz
// - enable clears stable flag, settles, sets
module scm_ctrl #(
  parameter int STABLE_CNT = scm_pkg::STABLE_CYCLES
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // cpu side events, same clock
  input wire logic halt_req,
  input wire logic wake_req,
  input wire logic watchdog_en,
  // oscillator outputs, asynchronous
  input wire logic int_fast_rc,
  input wire logic ext_fast_crystal,
  input wire logic ext_watch_crystal,
  input wire logic int_slow_rc,
  // oscillator ready levels, asynchronous
  input wire logic int_fast_rc_ready,
  input wire logic ext_fast_crystal_ready,
  input wire logic ext_watch_crystal_ready,
  // oscillator power and trim
  output logic int_fast_rc_run,
  output logic ext_fast_crystal_run,
  output logic ext_watch_crystal_run,
  output logic int_slow_rc_run,
  output logic [3:0] fast_rc_mhz,
  output logic fast_crystal_range,
  // clocks and mode
  output logic sys_clk,
  output logic fast_clk_on,
  output logic sub_clk_on,
  output logic cpu_run,
  output logic [2:0] op_mode
);
  // control register fields
  logic [2:0] sysclk_select_r; // system clock select
  logic fast_source_select_r; // fast source select
  logic slow_source_select_r; // slow source select
  logic halt_fast_keep_r; // fast oscillator kept in halt
  logic halt_slow_keep_r; // slow oscillator kept in halt
  logic [1:0] fast_rc_freq_sel_r; // rc frequency code
  logic fast_crystal_range_r; // crystal range bit
  logic [2:0] osc_en_r; // enable bits, rc/xtal/watch
  logic [2:0] osc_stable_r; // stable flags
  // mode machine
  scm_pkg::scm_mode_type mode_r;
  scm_pkg::scm_mode_type mode_nxt;
  // synchronised oscillator views
  logic [3:0] osc_edge; // any edge per oscillator
  logic [2:0] ready_lvl; // ready levels
  // bus decode
  logic wr_en; // write in access phase
  logic rd_setup; // read in setup phase
  logic addr_hit; // mapped offset
  logic [7:0] rd_mux; // read value
  // clock generator
  logic act_sub_r; // sub clock active source
  logic [2:0] act_div_r; // active divide code
  logic [5:0] div_cnt_r; // edge counter
  logic [5:0] div_lim; // edges per half period, less one
  logic want_sub; // requested source
  logic fast_edge; // selected fast edge
  logic sub_edge; // selected sub edge
  logic src_edge; // active source edge
  logic cfg_change; // new source or ratio pending
  logic sys_on; // system clock allowed by mode
  // oscillator run levels
  logic fast_allow; // mode lets fast run
  logic sub_allow; // mode lets sub run
  logic [2:0] osc_run; // enable outputs of the three
  logic slow_rc_need; // slow rc running
  // synchronise the four oscillator clocks, only edges are used
  scm_sync #(.WIDTH(4)) u_osc_sync (
    .pclk(pclk),
    .presetn(presetn),
    .async_in({int_slow_rc, ext_watch_crystal, ext_fast_crystal,
      int_fast_rc}),
    .level(),
    .edge_pulse(osc_edge)
  );
  // synchronise the ready levels, only levels are used
  scm_sync #(.WIDTH(3)) u_ready_sync (
    .pclk(pclk),
    .presetn(presetn),
    .async_in({ext_watch_crystal_ready, ext_fast_crystal_ready,
      int_fast_rc_ready}),
    .level(ready_lvl),
    .edge_pulse()
  );
  // apb strobes, zero wait states
  assign wr_en = psel && penable && pwrite;
  assign rd_setup = psel && !penable && !pwrite;
  assign pready = 1'b1;
  // offset decode
  always_comb begin
    addr_hit = 1'b1;
    rd_mux = 8'h00;
    unique case (paddr)
      scm_pkg::SYSCLK_CTRL_OFS: begin
        rd_mux = {sysclk_select_r, 1'b0, fast_source_select_r,
          slow_source_select_r, halt_fast_keep_r, halt_slow_keep_r};
      end
      scm_pkg::FAST_RC_CTRL_OFS: begin
        rd_mux = {4'h0, fast_rc_freq_sel_r,
          osc_stable_r[scm_pkg::OSC_FRC], osc_en_r[scm_pkg::OSC_FRC]};
      end
      scm_pkg::FAST_XTAL_CTRL_OFS: begin
        rd_mux = {5'h00, fast_crystal_range_r,
          osc_stable_r[scm_pkg::OSC_FXT], osc_en_r[scm_pkg::OSC_FXT]};
      end
      scm_pkg::WATCH_XTAL_CTRL_OFS: begin
        rd_mux = {6'h00, osc_stable_r[scm_pkg::OSC_WXT],
          osc_en_r[scm_pkg::OSC_WXT]};
      end
      scm_pkg::MODE_STATUS_OFS: rd_mux = {4'h0, cpu_run, mode_r};
      default: addr_hit = 1'b0; // unmapped
    endcase
  end
  // error answer on unmapped access
  assign pslverr = psel && penable && !addr_hit;
  // read data captured in setup, stands through access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (rd_setup) begin
      prdata <= {24'h00_0000, rd_mux};
    end
  end
  // system clock control register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sysclk_select_r <= scm_pkg::SYSCLK_CTRL_RST[scm_pkg::SEL_MSB:
        scm_pkg::SEL_LSB];
      fast_source_select_r <=
        scm_pkg::SYSCLK_CTRL_RST[scm_pkg::FAST_SRC_BIT];
      slow_source_select_r <=
        scm_pkg::SYSCLK_CTRL_RST[scm_pkg::SLOW_SRC_BIT];
      halt_fast_keep_r <= scm_pkg::SYSCLK_CTRL_RST[scm_pkg::FAST_KEEP_BIT];
      halt_slow_keep_r <= scm_pkg::SYSCLK_CTRL_RST[scm_pkg::SLOW_KEEP_BIT];
    end else if (wr_en && paddr == scm_pkg::SYSCLK_CTRL_OFS) begin
      sysclk_select_r <= pwdata[scm_pkg::SEL_MSB:scm_pkg::SEL_LSB];
      fast_source_select_r <= pwdata[scm_pkg::FAST_SRC_BIT];
      slow_source_select_r <= pwdata[scm_pkg::SLOW_SRC_BIT];
      halt_fast_keep_r <= pwdata[scm_pkg::FAST_KEEP_BIT];
      halt_slow_keep_r <= pwdata[scm_pkg::SLOW_KEEP_BIT];
    end
  end
  // oscillator control fields
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fast_rc_freq_sel_r <= scm_pkg::RC_FREQ_RST;
      fast_crystal_range_r <= 1'b0;
      osc_en_r <= {scm_pkg::WATCH_XTAL_EN_RST, scm_pkg::FAST_XTAL_EN_RST,
        scm_pkg::FAST_RC_EN_RST};
    end else if (wr_en) begin
      if (paddr == scm_pkg::FAST_RC_CTRL_OFS) begin
        fast_rc_freq_sel_r <=
          pwdata[scm_pkg::RC_FREQ_MSB:scm_pkg::RC_FREQ_LSB];
        osc_en_r[scm_pkg::OSC_FRC] <= pwdata[scm_pkg::ENABLE_BIT];
      end
      if (paddr == scm_pkg::FAST_XTAL_CTRL_OFS) begin
        // range is frozen while the crystal is enabled
        if (!osc_en_r[scm_pkg::OSC_FXT]) begin
          fast_crystal_range_r <= pwdata[scm_pkg::XTAL_RANGE_BIT];
        end
        osc_en_r[scm_pkg::OSC_FXT] <= pwdata[scm_pkg::ENABLE_BIT];
      end
      if (paddr == scm_pkg::WATCH_XTAL_CTRL_OFS) begin
        osc_en_r[scm_pkg::OSC_WXT] <= pwdata[scm_pkg::ENABLE_BIT];
      end
    end
  end
  // stable flag per oscillator: clear on enable, set after settling
  generate
    for (genvar gi = 0; gi < 3; gi++) begin : g_stable
      logic [7:0] settle_r; // ready cycles seen
      logic en_rise; // enable written from 0 to 1
      assign en_rise = wr_en && pwdata[scm_pkg::ENABLE_BIT] &&
        !osc_en_r[gi] &&
        ((gi == scm_pkg::OSC_FRC && paddr == scm_pkg::FAST_RC_CTRL_OFS) ||
         (gi == scm_pkg::OSC_FXT && paddr == scm_pkg::FAST_XTAL_CTRL_OFS) ||
         (gi == scm_pkg::OSC_WXT && paddr == scm_pkg::WATCH_XTAL_CTRL_OFS));
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          settle_r <= 8'h00;
          osc_stable_r[gi] <= 1'b0;
        end else if (en_rise || !osc_run[gi] || !ready_lvl[gi]) begin
          // restart settling, flag drops
          settle_r <= 8'h00;
          osc_stable_r[gi] <= 1'b0;
        end else if (settle_r == 8'(STABLE_CNT - 1)) begin
          osc_stable_r[gi] <= 1'b1;
        end else begin
          settle_r <= settle_r + 8'h01;
        end
      end
    end
  endgenerate
  // next mode from halt, wake and select writes
  always_comb begin
    mode_nxt = mode_r;
    unique case (mode_r)
      scm_pkg::MODE_FAST, scm_pkg::MODE_SLOW: begin
        if (halt_req) begin
          // halt picks mode from the keep bits now
          unique case ({halt_fast_keep_r, halt_slow_keep_r})
            2'b00: mode_nxt = scm_pkg::MODE_SLEEP;
            2'b01: mode_nxt = scm_pkg::MODE_IDLE_SLOW_ONLY;
            2'b11: mode_nxt = scm_pkg::MODE_IDLE_BOTH_OSC;
            2'b10: mode_nxt = scm_pkg::MODE_IDLE_FAST_ONLY;
          endcase
        end else if (sysclk_select_r == scm_pkg::SEL_SUB) begin
          mode_nxt = scm_pkg::MODE_SLOW;
        end else begin
          mode_nxt = scm_pkg::MODE_FAST;
        end
      end
      scm_pkg::MODE_SLEEP, scm_pkg::MODE_IDLE_SLOW_ONLY,
      scm_pkg::MODE_IDLE_BOTH_OSC, scm_pkg::MODE_IDLE_FAST_ONLY: begin
        // wake returns to the run mode the select names
        if (wake_req) begin
          mode_nxt = (sysclk_select_r == scm_pkg::SEL_SUB) ?
            scm_pkg::MODE_SLOW : scm_pkg::MODE_FAST;
        end
      end
      default: begin
        mode_nxt = scm_pkg::MODE_FAST; // illegal code recovery
      end
    endcase
  end
  // mode register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_r <= scm_pkg::MODE_FAST;
    end else begin
      mode_r <= mode_nxt;
    end
  end
  // which clocks each mode allows
  always_comb begin
    sys_on = 1'b1;
    fast_allow = 1'b1;
    sub_allow = 1'b1;
    unique case (mode_r)
      scm_pkg::MODE_SLEEP: begin
        sys_on = 1'b0;
        fast_allow = 1'b0;
        sub_allow = 1'b0;
      end
      scm_pkg::MODE_IDLE_SLOW_ONLY: begin
        fast_allow = 1'b0;
        sys_on = (sysclk_select_r == scm_pkg::SEL_SUB);
      end
      scm_pkg::MODE_IDLE_FAST_ONLY: begin
        sub_allow = 1'b0;
        sys_on = (sysclk_select_r != scm_pkg::SEL_SUB);
      end
      default: sys_on = 1'b1;
    endcase
  end
  // oscillator power: selected source runs when in use
  always_comb begin
    osc_run[scm_pkg::OSC_FRC] = fast_allow && (osc_en_r[scm_pkg::OSC_FRC] ||
      (!fast_source_select_r && mode_r != scm_pkg::MODE_SLOW));
    osc_run[scm_pkg::OSC_FXT] = fast_allow && (osc_en_r[scm_pkg::OSC_FXT] ||
      (fast_source_select_r && mode_r != scm_pkg::MODE_SLOW));
    osc_run[scm_pkg::OSC_WXT] = sub_allow && (osc_en_r[scm_pkg::OSC_WXT] ||
      slow_source_select_r);
    // slow rc only survives sleep for the watchdog
    slow_rc_need = (mode_r != scm_pkg::MODE_SLEEP) || watchdog_en;
  end
  // registered oscillator and status outputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      int_fast_rc_run <= 1'b0;
      ext_fast_crystal_run <= 1'b0;
      ext_watch_crystal_run <= 1'b0;
      int_slow_rc_run <= 1'b0;
      fast_clk_on <= 1'b0;
      sub_clk_on <= 1'b0;
      cpu_run <= 1'b0;
      op_mode <= 3'h0;
      fast_crystal_range <= 1'b0;
    end else begin
      int_fast_rc_run <= osc_run[scm_pkg::OSC_FRC];
      ext_fast_crystal_run <= osc_run[scm_pkg::OSC_FXT];
      ext_watch_crystal_run <= osc_run[scm_pkg::OSC_WXT];
      int_slow_rc_run <= slow_rc_need;
      fast_clk_on <= fast_allow && (mode_r != scm_pkg::MODE_SLOW ||
        osc_en_r[fast_source_select_r]);
      sub_clk_on <= sub_allow;
      cpu_run <= (mode_nxt == scm_pkg::MODE_FAST) ||
        (mode_nxt == scm_pkg::MODE_SLOW);
      op_mode <= mode_nxt;
      fast_crystal_range <= fast_crystal_range_r;
    end
  end
  // rc frequency decode, code 11 repeats 4 MHz
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fast_rc_mhz <= scm_pkg::RC_MHZ_4;
    end else begin
      unique case (fast_rc_freq_sel_r)
        2'b01: fast_rc_mhz <= scm_pkg::RC_MHZ_8;
        2'b10: fast_rc_mhz <= scm_pkg::RC_MHZ_12;
        default: fast_rc_mhz <= scm_pkg::RC_MHZ_4;
      endcase
    end
  end
  // source edges by the select bits
  assign fast_edge = fast_source_select_r ? osc_edge[scm_pkg::OSC_FXT] :
    osc_edge[scm_pkg::OSC_FRC];
  assign sub_edge = slow_source_select_r ? osc_edge[scm_pkg::OSC_WXT] :
    osc_edge[scm_pkg::OSC_SRC];
  assign want_sub = (sysclk_select_r == scm_pkg::SEL_SUB);
  assign src_edge = act_sub_r ? sub_edge : fast_edge;
  assign cfg_change = (act_sub_r != want_sub) ||
    (!want_sub && act_div_r != sysclk_select_r);
  // half period in edges: 2 to the divide code, one edge on the sub clock
  assign div_lim = act_sub_r ? 6'h00 : 6'((7'h01 << act_div_r) - 7'h01);
  // system clock generator, changes only in a low phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sys_clk <= 1'b0;
      act_sub_r <= 1'b0;
      act_div_r <= 3'h0;
      div_cnt_r <= 6'h00;
    end else if (!sys_clk && (cfg_change || !sys_on)) begin
      // hold low, so the low phase only lengthens
      act_sub_r <= want_sub;
      act_div_r <= want_sub ? act_div_r : sysclk_select_r;
      div_cnt_r <= 6'h00;
    end else if (src_edge) begin
      if (div_cnt_r == div_lim) begin
        sys_clk <= !sys_clk;
        div_cnt_r <= 6'h00;
      end else begin
        div_cnt_r <= div_cnt_r + 6'h01;
      end
    end
  end
endmodule : scm_ctrl

// ---- core/scm_pkg.sv ----
// shared constants for the system clock and mode controller
package scm_pkg;

  // clock figures
  localparam int CLK_PERIOD_NS = 100;
  localparam int STABLE_TIME_NS = 1000;
  // settle count rounds up to whole cycles
  localparam int STABLE_CYCLES =
    (STABLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // register byte offsets on the bus
  localparam logic [7:0] SYSCLK_CTRL_OFS = 8'h00;
  localparam logic [7:0] FAST_RC_CTRL_OFS = 8'h04;
  localparam logic [7:0] FAST_XTAL_CTRL_OFS = 8'h08;
  localparam logic [7:0] WATCH_XTAL_CTRL_OFS = 8'h0C;
  localparam logic [7:0] MODE_STATUS_OFS = 8'h10;

  // system clock control field positions
  localparam int SEL_MSB = 7;
  localparam int SEL_LSB = 5;
  localparam int FAST_SRC_BIT = 3;
  localparam int SLOW_SRC_BIT = 2;
  localparam int FAST_KEEP_BIT = 1;
  localparam int SLOW_KEEP_BIT = 0;

  // oscillator control field positions
  localparam int RC_FREQ_MSB = 3;
  localparam int RC_FREQ_LSB = 2;
  localparam int XTAL_RANGE_BIT = 2;
  localparam int STABLE_BIT = 1;
  localparam int ENABLE_BIT = 0;

  // values after reset
  localparam logic [7:0] SYSCLK_CTRL_RST = 8'h00;
  localparam logic [1:0] RC_FREQ_RST = 2'h0;
  localparam logic FAST_RC_EN_RST = 1'b1;
  localparam logic FAST_XTAL_EN_RST = 1'b0;
  localparam logic WATCH_XTAL_EN_RST = 1'b0;

  // select code meaning the sub clock
  localparam logic [2:0] SEL_SUB = 3'h7;

  // oscillator indices
  localparam int OSC_FRC = 0;
  localparam int OSC_FXT = 1;
  localparam int OSC_WXT = 2;
  localparam int OSC_SRC = 3;

  // internal fast rc frequency in MHz
  localparam logic [3:0] RC_MHZ_4 = 4'h4;
  localparam logic [3:0] RC_MHZ_8 = 4'h8;
  localparam logic [3:0] RC_MHZ_12 = 4'hC;

  // operating modes
  typedef enum logic [2:0] {
    MODE_FAST = 3'b000,
    MODE_SLOW = 3'b001,
    MODE_SLEEP = 3'b010,
    MODE_IDLE_SLOW_ONLY = 3'b011,
    MODE_IDLE_BOTH_OSC = 3'b100,
    MODE_IDLE_FAST_ONLY = 3'b101
  } scm_mode_type;

endpackage : scm_pkg

// ---- core/scm_sync.sv ----
`timescale 1ns/1ps
// two-flop synchroniser with edge detect on the settled copy
module scm_sync #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // asynchronous inputs
  input wire logic [WIDTH-1:0] async_in,
  // synchronised level and any-edge pulse
  output logic [WIDTH-1:0] level,
  output logic [WIDTH-1:0] edge_pulse
);

  logic [WIDTH-1:0] meta_r; // first stage, read only by second
  logic [WIDTH-1:0] sync_r; // second stage
  logic [WIDTH-1:0] last_r; // delayed copy for edge detect

  // synchroniser chain
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_r <= '0;
      sync_r <= '0;
      last_r <= '0;
    end else begin
      meta_r <= async_in;
      sync_r <= meta_r;
      last_r <= sync_r;
    end
  end

  assign level = sync_r;
  assign edge_pulse = sync_r ^ last_r;

endmodule : scm_sync

// ---- verif/scm_chk.sv ----
`timescale 1ns/1ps
// watches mode, gating and register effects at the ports
module scm_chk (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb side
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  // cpu events
  input wire logic halt_req,
  input wire logic watchdog_en,
  // watched outputs
  input wire logic int_slow_rc_run,
  input wire logic [3:0] fast_rc_mhz,
  input wire logic sys_clk,
  input wire logic fast_clk_on,
  input wire logic sub_clk_on,
  input wire logic cpu_run,
  input wire logic [2:0] op_mode
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic wr; // completed write
  logic [7:0] scc_r; // shadow of select register
  logic [1:0] frq_r; // shadow of rc frequency code
  logic [2:0] halt_exp; // mode a halt should give
  logic [3:0] mhz_exp; // expected rc frequency
  assign wr = psel && penable && pwrite && pready;
  // follow software writes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scc_r <= 8'h00;
      frq_r <= 2'h0;
    end else if (wr && paddr == 8'h00) begin
      scc_r <= pwdata[7:0];
    end else if (wr && paddr == 8'h04) begin
      frq_r <= pwdata[3:2];
    end
  end
  // keep bits pick the cpu-off mode
  always_comb begin
    case (scc_r[1:0])
      2'h0: halt_exp = 3'h2;
      2'h1: halt_exp = 3'h3;
      2'h2: halt_exp = 3'h5;
      default: halt_exp = 3'h4;
    endcase
  end
  assign mhz_exp = (frq_r == 2'h2) ? 4'hC : (frq_r == 2'h1) ? 4'h8 : 4'h4;
  property p_run;
    op_mode > 3'h1 |-> !cpu_run;
  endproperty
  a_run: assert property (p_run)
    else $error("cpu runs in an off mode");
  property p_halt;
    cpu_run && halt_req |=> op_mode == halt_exp && !cpu_run;
  endproperty
  a_halt: assert property (p_halt)
    else $error("halt gave wrong mode");
  property p_sleep_clk;
    (op_mode == 3'h2) [*3] |-> !fast_clk_on && !sub_clk_on;
  endproperty
  a_sleep_clk: assert property (p_sleep_clk)
    else $error("clock left on in sleep");
  property p_wdt;
    (op_mode == 3'h2 && !watchdog_en) [*3] |-> !int_slow_rc_run;
  endproperty
  a_wdt: assert property (p_wdt)
    else $error("slow rc runs in sleep without watchdog");
  property p_idle_slow_only_clk;
    (op_mode == 3'h3) [*3] |-> !fast_clk_on && sub_clk_on;
  endproperty
  a_idle_slow_only_clk: assert property (p_idle_slow_only_clk)
    else $error("wrong gating in slow-only idle");
  property p_sel;
    wr && paddr == 8'h00 && cpu_run && !halt_req
      |-> ##[1:2] op_mode == {2'b00, scc_r[7:5] == 3'h7};
  endproperty
  a_sel: assert property (p_sel)
    else $error("run mode does not follow select");
  property p_mhz;
    wr && paddr == 8'h04 |=> ##1 fast_rc_mhz == mhz_exp;
  endproperty
  a_mhz: assert property (p_mhz)
    else $error("rc frequency mismatch");
  property p_phase;
    $rose(sys_clk) |=> sys_clk;
  endproperty
  a_phase: assert property (p_phase)
    else $error("short high phase on system clock");
  c_sleep: cover property (cpu_run && halt_req && scc_r[1:0] == 2'h0);
  c_slow: cover property (op_mode == 3'h1);
  c_wdt: cover property (op_mode == 3'h2 && watchdog_en);
endmodule : scm_chk

bind scm_ctrl scm_chk u_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
  .halt_req(halt_req), .watchdog_en(watchdog_en),
  .int_slow_rc_run(int_slow_rc_run), .fast_rc_mhz(fast_rc_mhz),
  .sys_clk(sys_clk), .fast_clk_on(fast_clk_on), .sub_clk_on(sub_clk_on),
  .cpu_run(cpu_run), .op_mode(op_mode)
);

// ---- verif/tb_top.sv ----
`timescale 1ns/1ps
// self-checking bench for the clock and mode controller
module tb_top;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [7:0] cyc = 8'h00; // free-running cycle count
  logic [2:0] rdy = 3'h7; // oscillator ready levels
  logic [31:0] pwdata, prdata, rnd;
  logic halt_req, wake_req, watchdog_en, sys_clk, cpu_run;
  logic int_fast_rc, ext_fast_crystal, ext_watch_crystal, int_slow_rc;
  logic int_fast_rc_run, ext_fast_crystal_run, ext_watch_crystal_run;
  logic int_slow_rc_run, fast_crystal_range, fast_clk_on, sub_clk_on;
  logic [3:0] fast_rc_mhz;
  logic [2:0] op_mode;
  int failures, num_checks;
  int mz[4] = '{4, 8, 12, 4}; // rc frequency per code
  logic [2:0] hm[4] = '{3'h2, 3'h3, 3'h5, 3'h4}; // halt mode per keep
  // oscillators all slower than half the bus clock
  assign int_fast_rc = cyc[1];
  assign ext_fast_crystal = cyc[2];
  assign ext_watch_crystal = cyc[3];
  assign int_slow_rc = cyc[2];
  scm_ctrl #(.STABLE_CNT(4)) dut_u (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .halt_req(halt_req),
    .wake_req(wake_req), .watchdog_en(watchdog_en),
    .int_fast_rc(int_fast_rc), .ext_fast_crystal(ext_fast_crystal),
    .ext_watch_crystal(ext_watch_crystal), .int_slow_rc(int_slow_rc),
    .int_fast_rc_ready(rdy[0]), .ext_fast_crystal_ready(rdy[1]),
    .ext_watch_crystal_ready(rdy[2]), .int_fast_rc_run(int_fast_rc_run),
    .ext_fast_crystal_run(ext_fast_crystal_run),
    .ext_watch_crystal_run(ext_watch_crystal_run),
    .int_slow_rc_run(int_slow_rc_run), .fast_rc_mhz(fast_rc_mhz),
    .fast_crystal_range(fast_crystal_range), .sys_clk(sys_clk),
    .fast_clk_on(fast_clk_on), .sub_clk_on(sub_clk_on),
    .cpu_run(cpu_run), .op_mode(op_mode)
  );
  // bus clock, 100 ns period
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  // free-running count feeds the oscillator waves
  always @(posedge pclk) begin
    cyc <= cyc + 8'h01;
  end
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction : lfsr
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    num_checks++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  // one apb transfer, held until pready
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] r,
                     output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0, r, e);
    chk("rdata", r, x);
  endtask : rd
  // let edges pass, then sample settled outputs
  task automatic wt(input int n);
    repeat (n) @(posedge pclk);
    @(negedge pclk);
  endtask : wt
  // one-cycle halt or wake pulse
  task automatic pulse(input logic h);
    @(posedge pclk);
    if (h) halt_req <= 1'b1;
    else wake_req <= 1'b1;
    @(posedge pclk);
    halt_req <= 1'b0;
    wake_req <= 1'b0;
  endtask : pulse
  // wait for the system clock to show a level
  task automatic wv(input logic v);
    int n;
    n = 0;
    while (sys_clk !== v && n < 400) begin
      @(negedge pclk);
      n++;
    end
  endtask : wv
  task automatic finish_test;
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : finish_test
  // hang guard
  initial begin
    repeat (20000) @(posedge pclk);
    failures++;
    finish_test();
  end
  initial begin
    logic [31:0] r;
    logic e;
    logic [7:0] d;
    int p;
    int s;
    {presetn, psel, penable, pwrite, halt_req, wake_req} = 6'h00;
    {paddr, pwdata, watchdog_en} = '0;
    {failures, num_checks} = '0;
    rnd = 32'h57273EF7;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    wt(12);
    rd(8'h00, 32'h0);
    rd(8'h04, 32'h3);
    rd(8'h08, 32'h0);
    rd(8'h0C, 32'h0);
    rd(8'h10, 32'h8);
    apb(1'b0, 8'h14, 32'h0, r, e);
    chk("unmapped_err", e, 1'b1);
    chk("unmapped_data", r, 32'h0);
    $display("test reset done");
    // every keep pair from fast and slow, random sources
    for (int i = 0; i < 8; i++) begin
      rnd = lfsr(rnd);
      d[7:5] = i[2] ? 3'h7 : rnd[10:8] % 3'h7;
      d[4:0] = {1'b0, rnd[3:2], i[1:0]};
      @(posedge pclk);
      watchdog_en <= rnd[0];
      wr(8'h00, {24'h0, d});
      wt(4);
      rd(8'h00, {24'h0, d});
      chk("run_mode", op_mode, {2'b00, i[2]});
      chk("fxt_run", ext_fast_crystal_run, rnd[3] & ~i[2]);
      chk("wxt_run", ext_watch_crystal_run, rnd[2]);
      pulse(1'b1);
      wt(4);
      chk("halt_mode", op_mode, hm[i[1:0]]);
      chk("cpu_off", cpu_run, 1'b0);
      chk("fast_on", fast_clk_on, i[1]);
      chk("sub_on", sub_clk_on, i[0]);
      chk("slow_rc", int_slow_rc_run, (i[1:0] != 0) | rnd[0]);
      pulse(1'b0);
      wt(4);
      chk("wake_mode", op_mode, {2'b00, i[2]});
    end
    $display("test modes done");
    // rc codes while slow, enable follows bit
    wr(8'h00, 32'hE0);
    for (int f = 0; f < 4; f++) begin
      wr(8'h04, 32'(f * 4 + f % 2));
      wt(4);
      chk("rc_run", int_fast_rc_run, f % 2);
      chk("rc_mhz", fast_rc_mhz, mz[f]);
    end
    $display("test slow rc done");
    wr(8'h00, 32'h0);
    wt(4);
    wr(8'h08, 32'h1);
    rd(8'h08, 32'h1);
    wt(12);
    rd(8'h08, 32'h3);
    wr(8'h08, 32'h5);
    rd(8'h08, 32'h3);
    chk("range", fast_crystal_range, 1'b0);
    // crystal ready drops: stable flag must fall
    rdy <= 3'h5;
    wt(4);
    rd(8'h08, 32'h1);
    rdy <= 3'h7;
    wr(8'h08, 32'h0);
    $display("test stable flag done");
    // high phase length for divide codes 0, 2 and 4 and for the sub clock
    for (int j = 0; j < 4; j++) begin
      s = (j == 3) ? 7 : 2 * j;
      wr(8'h00, 32'(s * 32));
      wt(40);
      wv(1'b0);
      wv(1'b1);
      p = 0;
      while (sys_clk === 1'b1 && p < 400) begin
        @(negedge pclk);
        p++;
      end
      chk("high_phase", p, (s == 7) ? 4 : 2 << s);
    end
    $display("test divider done");
    finish_test();
  end
endmodule : tb_top
